// ===== rtl/tbr_router.sv
// Overview of operation
// - mode byte: 1 analog, 2 digital
// - swap byte picks which debug bus routes
// - only pad_map_count table entries applied
// - entry: high nibble pad, low bit
// - pad codes irq auxiliary_pad_second dwl auxiliary_pad_first; rest reserved
// - codes 0-7 bus bit, 8 carrier
// - analog: dac one irq, two auxiliary_pad_second
// - at most two analog, four digital
// - nothing out while enable bit clear
// - command low nibble picks signal; 8 carrier
// - command high nibble picks output pad
// - seven documented group codes
// - command pads Q, general, auxiliary_pad_second, auxiliary_pad_first
// - timer group codes 7 to 2
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module tbr_router #(
    parameter int unsigned ADDR_W = tbr_pkg::ADDR_W_DEF,
    parameter int unsigned MAP_ENTRIES = tbr_pkg::MAP_ENTRIES_DEF
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [7:0] debug_bus_zero,
    input wire logic [7:0] debug_bus_one,
    input wire logic [7:0] grp_clock,
    input wire logic [7:0] grp_tx,
    input wire logic [7:0] grp_timer,
    input wire logic [7:0] grp_card,
    input wire logic [7:0] grp_trx,
    input wire logic [7:0] grp_rxdt,
    input wire logic [7:0] grp_rxerr,
    input wire logic carrier_clk_pin,
    output logic irq_pad_out,
    output logic irq_pad_oe,
    output logic aux_second_out,
    output logic aux_second_oe,
    output logic download_request_out,
    output logic download_request_oe,
    output logic aux_first_out,
    output logic aux_first_oe,
    output logic q_pad_out,
    output logic q_pad_oe,
    output logic general_output_out,
    output logic general_output_oe,
    output logic analog_out_one_active,
    output logic analog_out_two_active,
    output logic [7:0] analog_out_one_sel,
    output logic [7:0] analog_out_two_sel
);
    import tbr_pkg::*;

    if (ADDR_W < 10) begin : g_chk_addr
        $error("ADDR_W must be at least 10");
    end
    if ((MAP_ENTRIES < 1) || (MAP_ENTRIES > 4)) begin : g_chk_map
        $error("MAP_ENTRIES must be 1 to 4");
    end

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] idx);
        hit = (a == ADDR_W'({idx, 2'b00}));
    endfunction : hit

    logic ack;
    logic wr;
    logic [7:0] test_bus_mode_select;
    logic [7:0] test_bus_source_select;
    logic [7:0] test_bus_swap_control;
    logic [7:0] pad_map_count;
    logic [31:0] pad_map_table;
    logic [7:0] analog_out_one_source;
    logic [7:0] analog_out_two_source;
    logic debug_output_enable;
    logic [7:0] cmd_signal_select;
    logic cmd_valid;
    logic car_s1;
    logic car_s2;
    logic [NUM_PADS-1:0] pad_lvl;
    logic [NUM_PADS-1:0] pad_oe;
    logic [NUM_PADS-1:0] next_lvl;
    logic [NUM_PADS-1:0] next_oe;
    logic debug_on;
    logic analog_on;
    logic [7:0] routed_bus;
    logic [7:0] grp_bits;
    logic [7:0] grp_mask;
    logic [MAP_ENTRIES-1:0] tab_lvl;
    logic [MAP_ENTRIES-1:0] tab_act;
    logic cmd_lvl;
    logic cmd_act;
    logic cmd_drives;
    logic [31:0] next_rd;

    // one wait cycle per access keeps the decode off the bus path
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (read || write) && !ack;
        end
    end
    assign waitrequest = !ack;
    assign wr = write && ack;

    always_comb begin
        next_rd = 32'h0000_0000;
        if (hit(address, IDX_MODE)) begin
            next_rd[7:0] = test_bus_mode_select;
        end else if (hit(address, IDX_SRC)) begin
            next_rd[7:0] = test_bus_source_select;
        end else if (hit(address, IDX_SWAP)) begin
            next_rd[7:0] = test_bus_swap_control;
        end else if (hit(address, IDX_COUNT)) begin
            next_rd[7:0] = pad_map_count;
        end else if (hit(address, IDX_MAP)) begin
            next_rd = pad_map_table;
        end else if (hit(address, IDX_DAC1)) begin
            next_rd[7:0] = analog_out_one_source;
        end else if (hit(address, IDX_DAC2)) begin
            next_rd[7:0] = analog_out_two_source;
        end else if (hit(address, IDX_CTRL)) begin
            next_rd[CTRL_EN_BIT] = debug_output_enable;
        end else if (hit(address, IDX_CMD)) begin
            next_rd[15:0] = {cmd_signal_select, test_bus_source_select};
        end else if (hit(address, IDX_STAT)) begin
            next_rd[NUM_PADS-1:0] = pad_oe;
            next_rd[STAT_LVL_LSB +: NUM_PADS] = pad_lvl;
            next_rd[STAT_DIG_BIT] = debug_on;
            next_rd[STAT_ANA_BIT] = analog_on;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            readdata <= 32'h0000_0000;
        end else if (read && !ack) begin
            readdata <= next_rd;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            test_bus_mode_select <= RST_BYTE;
            test_bus_swap_control <= RST_BYTE;
            pad_map_count <= RST_BYTE;
            analog_out_one_source <= RST_BYTE;
            analog_out_two_source <= RST_BYTE;
            debug_output_enable <= 1'b0;
        end else if (wr && byteenable[0]) begin
            if (hit(address, IDX_MODE)) begin
                test_bus_mode_select <= writedata[7:0];
            end
            if (hit(address, IDX_SWAP)) begin
                test_bus_swap_control <= writedata[7:0];
            end
            if (hit(address, IDX_COUNT)) begin
                pad_map_count <= writedata[7:0];
            end
            if (hit(address, IDX_DAC1)) begin
                analog_out_one_source <= writedata[7:0];
            end
            if (hit(address, IDX_DAC2)) begin
                analog_out_two_source <= writedata[7:0];
            end
            if (hit(address, IDX_CTRL)) begin
                debug_output_enable <= writedata[CTRL_EN_BIT];
            end
        end
    end

    for (genvar b = 0; b < 4; b++) begin : g_map_lane
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                pad_map_table[8*b +: 8] <= RST_MAP[8*b +: 8];
            end else if (wr && byteenable[b] && hit(address, IDX_MAP)) begin
                pad_map_table[8*b +: 8] <= writedata[8*b +: 8];
            end
        end
    end

    // a command needs both parameter bytes in one write
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            test_bus_source_select <= RST_BYTE;
            cmd_signal_select <= RST_BYTE;
            cmd_valid <= 1'b0;
        end else if (wr && hit(address, IDX_CMD) && (&byteenable[1:0])) begin
            test_bus_source_select <= writedata[7:0];
            cmd_signal_select <= writedata[15:8];
            cmd_valid <= 1'b1;
        end else if (wr && byteenable[0] && hit(address, IDX_SRC)) begin
            test_bus_source_select <= writedata[7:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            car_s1 <= 1'b0;
            car_s2 <= 1'b0;
        end else begin
            car_s1 <= carrier_clk_pin;
            car_s2 <= car_s1;
        end
    end

    assign debug_on = debug_output_enable && (test_bus_mode_select == MODE_DIGITAL);
    assign analog_on = debug_output_enable && (test_bus_mode_select == MODE_ANALOG);
    assign routed_bus = (test_bus_swap_control == SWAP_ONE) ? debug_bus_one
                                                            : debug_bus_zero;

    // entries beyond the count stay off
    for (genvar i = 0; i < MAP_ENTRIES; i++) begin : g_entry
        tbr_pad_source u_src (
            .en(debug_on && (pad_map_count > 8'(i))
                && !(cmd_drives && (i == 3))),
            .sel(pad_map_table[8*i+SIG_LSB +: 4]),
            .bits(routed_bus),
            .mask(MASK_FULL),
            .carrier(car_s2),
            .level(tab_lvl[i]),
            .active(tab_act[i])
        );
    end

    always_comb begin
        case (test_bus_source_select)
            GRP_CLOCK: grp_bits = grp_clock;
            GRP_TX: grp_bits = grp_tx;
            GRP_TIMER: grp_bits = grp_timer;
            GRP_CARD: grp_bits = grp_card;
            GRP_TRX: grp_bits = grp_trx;
            GRP_RXDT: grp_bits = grp_rxdt;
            GRP_RXERR: grp_bits = grp_rxerr;
            default: grp_bits = 8'h00;
        endcase
    end
    assign grp_mask = tbr_group_mask(test_bus_source_select);

    tbr_pad_source u_cmd (
        .en(debug_on && cmd_valid),
        .sel(cmd_signal_select[SIG_LSB +: 4]),
        .bits(grp_bits),
        .mask(grp_mask),
        .carrier(car_s2),
        .level(cmd_lvl),
        .active(cmd_act)
    );
    // a driving command displaces entry three, keeping four pads
    assign cmd_drives = cmd_act
        && (cmd_signal_select[PAD_LSB +: 4] < PAD_CODES);

    // the command wins a shared aux pad; lower table entries win ties
    always_comb begin
        next_lvl = '0;
        next_oe = '0;
        for (int k = MAP_ENTRIES - 1; k >= 0; k--) begin
            if (tab_act[k] && (pad_map_table[8*k+PAD_LSB +: 4] < PAD_CODES)) begin
                next_oe[pad_map_table[8*k+PAD_LSB +: 2]] = 1'b1;
                next_lvl[pad_map_table[8*k+PAD_LSB +: 2]] = tab_lvl[k];
            end
        end
        if (cmd_act) begin
            case (cmd_signal_select[PAD_LSB +: 4])
                CPAD_Q: begin
                    next_oe[P_Q] = 1'b1;
                    next_lvl[P_Q] = cmd_lvl;
                end
                CPAD_GPO: begin
                    next_oe[P_GPO] = 1'b1;
                    next_lvl[P_GPO] = cmd_lvl;
                end
                CPAD_AUXILIARY_PAD_SECOND: begin
                    next_oe[P_AUXILIARY_PAD_SECOND] = 1'b1;
                    next_lvl[P_AUXILIARY_PAD_SECOND] = cmd_lvl;
                end
                CPAD_AUXILIARY_PAD_FIRST: begin
                    next_oe[P_AUXILIARY_PAD_FIRST] = 1'b1;
                    next_lvl[P_AUXILIARY_PAD_FIRST] = cmd_lvl;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pad_lvl <= '0;
            pad_oe <= '0;
        end else begin
            pad_lvl <= next_lvl;
            pad_oe <= next_oe;
        end
    end

    // dac sources to irq and auxiliary_pad_second
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            analog_out_one_active <= 1'b0;
            analog_out_two_active <= 1'b0;
            analog_out_one_sel <= RST_BYTE;
            analog_out_two_sel <= RST_BYTE;
        end else begin
            analog_out_one_active <= analog_on;
            analog_out_two_active <= analog_on;
            analog_out_one_sel <= analog_out_one_source;
            analog_out_two_sel <= analog_out_two_source;
        end
    end

    assign irq_pad_out = pad_lvl[P_IRQ];
    assign irq_pad_oe = pad_oe[P_IRQ];
    assign aux_second_out = pad_lvl[P_AUXILIARY_PAD_SECOND];
    assign aux_second_oe = pad_oe[P_AUXILIARY_PAD_SECOND];
    assign download_request_out = pad_lvl[P_DWL];
    assign download_request_oe = pad_oe[P_DWL];
    assign aux_first_out = pad_lvl[P_AUXILIARY_PAD_FIRST];
    assign aux_first_oe = pad_oe[P_AUXILIARY_PAD_FIRST];
    assign q_pad_out = pad_lvl[P_Q];
    assign q_pad_oe = pad_oe[P_Q];
    assign general_output_out = pad_lvl[P_GPO];
    assign general_output_oe = pad_oe[P_GPO];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_bus_answer: assert property ((read || write) && waitrequest
        |=> !waitrequest)
        else $error("no answer one cycle after request");
    a_analog_dacs: assert property (analog_on |=>
        analog_out_one_active && analog_out_two_active
        && !irq_pad_oe && !aux_second_oe)
        else $error("analog mode did not switch dacs");
    a_swap_route: assert property (debug_on && pad_map_count != 8'h00
        && pad_map_table[7:0] == 8'h03 && test_bus_swap_control == SWAP_ONE
        |=> irq_pad_oe && irq_pad_out == $past(debug_bus_one[3]))
        else $error("swapped bus not routed");
    a_count_zero: assert property (debug_on && pad_map_count == 8'h00
        && !cmd_valid |=> pad_oe == '0)
        else $error("pad driven with zero map count");
    a_entry_route: assert property (debug_on
        && pad_map_count >= 8'h03 && pad_map_table == 32'h3625_1803
        && test_bus_swap_control == 8'h00
        |=> download_request_oe
        && download_request_out == $past(debug_bus_zero[5]))
        else $error("table entry not routed");
    a_pad_reserved: assert property (debug_on && !cmd_valid
        && pad_map_count >= 8'h04 && pad_map_table == 32'h3943_2551
        |=> pad_oe == 6'h04)
        else $error("reserved pad code drove a pad");
    a_carrier_tab: assert property (debug_on && !cmd_valid
        && pad_map_count >= 8'h02 && pad_map_table[15:0] == 16'h1803
        |=> aux_second_oe && aux_second_out == $past(car_s2))
        else $error("carrier not on aux second pad");
    a_analog_src: assert property (analog_on ##1 analog_on |=>
        analog_out_one_sel == $past(analog_out_one_source)
        && analog_out_two_sel == $past(analog_out_two_source))
        else $error("dac source select lost");
    a_pad_limit: assert property ($countones(pad_oe) <= 4
        && !(analog_out_one_active && pad_oe != '0))
        else $error("too many test outputs");
    a_enable_off: assert property (!debug_output_enable |=> pad_oe == '0
        && !analog_out_one_active && !analog_out_two_active)
        else $error("output while enable clear");
    a_cmd_carrier: assert property (debug_on && cmd_valid
        && grp_mask != MASK_NONE && cmd_signal_select == 8'h08
        |=> q_pad_oe && q_pad_out == $past(car_s2))
        else $error("command carrier missing on q pad");
    a_cmd_pad: assert property (debug_on && cmd_valid
        && test_bus_source_select == GRP_CLOCK && cmd_signal_select == 8'h15
        |=> general_output_oe && general_output_out == $past(grp_clock[5]))
        else $error("command pad select wrong");
    a_group_rxdt: assert property (debug_on && cmd_valid
        && test_bus_source_select == GRP_RXDT && cmd_signal_select == 8'h10
        |=> general_output_oe && general_output_out == $past(grp_rxdt[0]))
        else $error("receiver group signal not routed");
    a_cmd_auxiliary_pad_first: assert property (debug_on && cmd_valid
        && test_bus_source_select == GRP_CARD && cmd_signal_select == 8'h32
        |=> aux_first_oe && aux_first_out == $past(grp_card[2]))
        else $error("aux first pad code wrong");
    a_timer_codes: assert property (debug_on && cmd_valid
        && test_bus_source_select == GRP_TIMER
        && cmd_signal_select[7:4] == 4'h0
        |=> q_pad_oe == ($past(cmd_signal_select[3:0]) inside {[4'h2:4'h8]}))
        else $error("timer code validity wrong");
    a_group_reserved: assert property (debug_on && cmd_valid
        && grp_mask == MASK_NONE && cmd_signal_select[7:4] == 4'h0
        |=> !q_pad_oe)
        else $error("reserved group drove q pad");

    c_table_route: cover property (debug_on && pad_map_count == 8'h04
        ##1 pad_oe[3:0] == 4'hf);
    c_cmd_route: cover property (debug_on && cmd_act ##1 q_pad_oe);
    c_analog: cover property (analog_on ##1 analog_out_one_active);
    c_read_stat: cover property (read && hit(address, IDX_STAT) && ack);

endmodule : tbr_router

// ===== rtl/tbr_pkg.sv
package tbr_pkg;

    // register indexes; the byte address is four times the index
    localparam logic [7:0] IDX_MODE = 8'hf0;
    localparam logic [7:0] IDX_SRC = 8'hf1;
    localparam logic [7:0] IDX_SWAP = 8'hf2;
    localparam logic [7:0] IDX_COUNT = 8'hf3;
    localparam logic [7:0] IDX_MAP = 8'hf4;
    localparam logic [7:0] IDX_DAC1 = 8'hf8;
    localparam logic [7:0] IDX_DAC2 = 8'hf9;
    localparam logic [7:0] IDX_CTRL = 8'h17;
    localparam logic [7:0] IDX_CMD = 8'h20;
    localparam logic [7:0] IDX_STAT = 8'h21;

    localparam int unsigned ADDR_W_DEF = 10;
    localparam int unsigned MAP_ENTRIES_DEF = 4;

    localparam logic [7:0] MODE_ANALOG = 8'h01;
    localparam logic [7:0] MODE_DIGITAL = 8'h02;
    localparam logic [7:0] SWAP_ONE = 8'h01;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_MAP = 32'h0000_0000;

    // field positions
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned PAD_LSB = 4;
    localparam int unsigned SIG_LSB = 0;
    localparam int unsigned STAT_LVL_LSB = 8;
    localparam int unsigned STAT_DIG_BIT = 16;
    localparam int unsigned STAT_ANA_BIT = 17;

    localparam logic [3:0] SEL_CARRIER = 4'h8;
    localparam logic [3:0] PAD_CODES = 4'h4;

    // pad indexes inside the router
    localparam int unsigned P_IRQ = 0;
    localparam int unsigned P_AUXILIARY_PAD_SECOND = 1;
    localparam int unsigned P_DWL = 2;
    localparam int unsigned P_AUXILIARY_PAD_FIRST = 3;
    localparam int unsigned P_Q = 4;
    localparam int unsigned P_GPO = 5;
    localparam int unsigned NUM_PADS = 6;

    // command pad codes
    localparam logic [3:0] CPAD_Q = 4'h0;
    localparam logic [3:0] CPAD_GPO = 4'h1;
    localparam logic [3:0] CPAD_AUXILIARY_PAD_SECOND = 4'h2;
    localparam logic [3:0] CPAD_AUXILIARY_PAD_FIRST = 4'h3;

    localparam logic [7:0] GRP_CLOCK = 8'h01;
    localparam logic [7:0] GRP_TX = 8'h1b;
    localparam logic [7:0] GRP_TIMER = 8'h1d;
    localparam logic [7:0] GRP_CARD = 8'h30;
    localparam logic [7:0] GRP_TRX = 8'h58;
    localparam logic [7:0] GRP_RXDT = 8'h70;
    localparam logic [7:0] GRP_RXERR = 8'h73;

    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_TX = 8'h03;
    localparam logic [7:0] MASK_TIMER = 8'hfc;
    localparam logic [7:0] MASK_RXERR = 8'hc7;
    localparam logic [7:0] MASK_NONE = 8'h00;

    // usable signal codes of a group; zero means a reserved group
    function automatic logic [7:0] tbr_group_mask(input logic [7:0] grp);
        case (grp)
            GRP_CLOCK, GRP_CARD, GRP_TRX, GRP_RXDT: tbr_group_mask = MASK_FULL;
            GRP_TX: tbr_group_mask = MASK_TX;
            GRP_TIMER: tbr_group_mask = MASK_TIMER;
            GRP_RXERR: tbr_group_mask = MASK_RXERR;
            default: tbr_group_mask = MASK_NONE;
        endcase
    endfunction : tbr_group_mask

endpackage : tbr_pkg

// ===== rtl/tbr_pad_source.sv
`timescale 1ns/1ps
module tbr_pad_source (
    input wire logic en,
    input wire logic [3:0] sel,
    input wire logic [7:0] bits,
    input wire logic [7:0] mask,
    input wire logic carrier,
    output logic level,
    output logic active
);
    import tbr_pkg::*;

    always_comb begin
        level = 1'b0;
        active = 1'b0;
        if (en && (mask != MASK_NONE)) begin
            if (sel == SEL_CARRIER) begin
                active = 1'b1;
                level = carrier;
            end else if (!sel[3] && mask[sel[2:0]]) begin
                active = 1'b1;
                level = bits[sel[2:0]];
            end
        end
    end

endmodule : tbr_pad_source

// ===== testbench/tbr_signal_source.sv
`timescale 1ns/1ps
module tbr_signal_source (
    input wire logic ref_clk,
    input wire logic flip,
    output logic [7:0] bus_zero,
    output logic [7:0] bus_one,
    output logic [55:0] groups,
    output logic carrier
);
    logic [7:0] m;
    logic [2:0] cnt = 3'h0;
    logic car_q = 1'b0;
    // flip inverts every bus and group level so the irq, dwl and auxiliary_pad_first pads are seen at both values
    assign m = {8{flip}};
    assign bus_zero = 8'ha5 ^ m;
    assign bus_one = 8'h3c ^ m;
    // rxerr, rxdt, trx, card, timer, tx, clock
    assign groups = {8'h8d, 8'h71, 8'hc3, 8'h4b, 8'h58, 8'h02, 8'h96} ^ {7{m}};
    // free running carrier, unrelated to the bus traffic
    always_ff @(posedge ref_clk) begin
        cnt <= (cnt == 3'h6) ? 3'h0 : cnt + 3'h1;
        if (cnt == 3'h6) begin
            car_q <= ~car_q;
        end
    end
    assign carrier = car_q;
endmodule : tbr_signal_source

// ===== testbench/tbr_router_tb.sv
`timescale 1ns/1ps
module tbr_router_tb;
    import tbr_pkg::*;
    localparam logic [7:0] GRPS [7] = '{GRP_CLOCK, GRP_TX, GRP_TIMER,
        GRP_CARD, GRP_TRX, GRP_RXDT, GRP_RXERR};
    localparam logic [3:0] CODES [7] = '{4'h5, 4'h1, 4'h7, 4'h2, 4'h6,
        4'h0, 4'h6};
    localparam int PIDX [4] = '{P_Q, P_GPO, P_AUXILIARY_PAD_SECOND, P_AUXILIARY_PAD_FIRST};
    logic ref_clk, rst_n, read, write, flip, car, waitrequest, a1, a2;
    logic [9:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [3:0] byteenable;
    logic [7:0] b0, b1, s1, s2;
    logic [55:0] g;
    logic [5:0] oe, lv;
    int miscompares, checked, cyc;

    tbr_signal_source i_src (.ref_clk(ref_clk), .flip(flip),
        .bus_zero(b0), .bus_one(b1), .groups(g), .carrier(car));
    tbr_router i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .debug_bus_zero(b0), .debug_bus_one(b1),
        .grp_clock(g[7:0]), .grp_tx(g[15:8]), .grp_timer(g[23:16]),
        .grp_card(g[31:24]), .grp_trx(g[39:32]), .grp_rxdt(g[47:40]),
        .grp_rxerr(g[55:48]), .carrier_clk_pin(car),
        .irq_pad_out(lv[0]), .irq_pad_oe(oe[0]), .aux_second_out(lv[1]),
        .aux_second_oe(oe[1]), .download_request_out(lv[2]),
        .download_request_oe(oe[2]), .aux_first_out(lv[3]),
        .aux_first_oe(oe[3]), .q_pad_out(lv[4]), .q_pad_oe(oe[4]),
        .general_output_out(lv[5]), .general_output_oe(oe[5]),
        .analog_out_one_active(a1), .analog_out_two_active(a2),
        .analog_out_one_sel(s1), .analog_out_two_sel(s2));

    task automatic tally_and_finish();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk_reg(input string nm, input logic [31:0] e, g_);
        checked++;
        if (g_ !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g_);
        end
    endtask : chk_reg

    task automatic chk_pad(input string nm, input logic [5:0] e, g_);
        checked++;
        if (g_ !== e) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", nm, e, g_);
        end
    endtask : chk_pad

    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr_, input logic [7:0] idx,
        input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        address <= {idx, 2'b00};
        write <= wr_;
        read <= ~wr_;
        writedata <= d;
        byteenable <= 4'hf;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 16);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        chk_pad("waitrequest", 6'h0, {5'h0, waitrequest});
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [31:0] e,
        input string nm);
        bus(1'b0, idx, 32'h0);
        chk_reg(nm, e, rd);
    endtask : rdc

    // pads follow a register write one edge after the bus answer
    task automatic pads(input logic [5:0] eoe, elv, m);
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk_pad("pad oe", eoe, oe);
        chk_pad("pad level", elv & m, lv & m);
    endtask : pads

    task automatic t_reset();
        pads(6'h0, 6'h0, 6'h3f);
        rdc(IDX_MODE, 32'h0, "mode");
        rdc(IDX_MAP, 32'h0, "map table");
        wr(8'h10, 32'hffff_ffff);
        rdc(8'h10, 32'h0, "unmapped");
        wr(IDX_MAP, 32'h1234_5678);
        rdc(IDX_MAP, 32'h1234_5678, "map table");
        wr(IDX_COUNT, 32'h0000_01a5);
        rdc(IDX_COUNT, 32'h0000_00a5, "count");
        $display("test reset done");
    endtask : t_reset

    task automatic t_table();
        wr(IDX_CTRL, 32'h1);
        wr(IDX_MODE, {24'h0, MODE_DIGITAL});
        wr(IDX_COUNT, 32'h2);
        wr(IDX_MAP, 32'h3625_1803);
        pads(6'h03, {5'h0, b0[3]}, 6'h01);
        wr(IDX_COUNT, 32'h4);
        pads(6'h0f, {2'h0, b0[6], b0[5], 1'b0, b0[3]}, 6'h0d);
        wr(IDX_SWAP, {24'h0, SWAP_ONE});
        pads(6'h0f, {2'h0, b1[6], b1[5], 1'b0, b1[3]}, 6'h0d);
        @(posedge ref_clk);
        flip <= 1'b1;
        @(posedge ref_clk);
        pads(6'h0f, {2'h0, b1[6], b1[5], 1'b0, b1[3]}, 6'h0d);
        // reserved pads in entries zero and two drive nothing, neither irq nor auxiliary_pad_second
        wr(IDX_MAP, 32'h3943_2551);
        pads(6'h04, {3'h0, b1[5], 2'h0}, 6'h3f);
        wr(IDX_MODE, 32'h0);
        pads(6'h0, 6'h0, 6'h3f);
        wr(IDX_MODE, {24'h0, MODE_DIGITAL});
        wr(IDX_CTRL, 32'h0);
        pads(6'h0, 6'h0, 6'h3f);
        $display("test table done");
    endtask : t_table

    task automatic t_analog();
        wr(IDX_CTRL, 32'h1);
        wr(IDX_MODE, {24'h0, MODE_ANALOG});
        wr(IDX_DAC1, 32'h05);
        wr(IDX_DAC2, 32'h09);
        pads(6'h0, 6'h0, 6'h3f);
        chk_reg("analog", 32'h0003_0905, {14'h0, a2, a1, s2, s1});
        rdc(IDX_STAT, 32'h0002_0000, "status");
        wr(IDX_MODE, {24'h0, MODE_DIGITAL});
        // the table left by the previous scenario comes back
        pads(6'h04, {3'h0, b1[5], 2'h0}, 6'h3f);
        chk_reg("analog act", 32'h0, {30'h0, a2, a1});
        $display("test analog done");
    endtask : t_analog

    task automatic t_cmd();
        int p;
        logic [7:0] v;
        wr(IDX_COUNT, 32'h0);
        for (int i = 0; i < 7; i++) begin
            wr(IDX_CMD, {18'h0, 2'(i % 4), CODES[i], GRPS[i]});
            p = PIDX[i % 4];
            v = g[i*8 +: 8];
            pads(6'(1 << p), 6'(v[CODES[i]] << p), 6'h3f);
        end
        wr(IDX_CMD, {16'h0, 8'h01, GRP_TIMER});
        pads(6'h0, 6'h0, 6'h3f);
        wr(IDX_CMD, {16'h0, 8'h08, 8'h02});
        pads(6'h0, 6'h0, 6'h3f);
        wr(IDX_CMD, {16'h0, 8'h08, GRP_TIMER});
        pads(6'h10, 6'h0, 6'h2f);
        wr(IDX_CMD, {16'h0, 8'h40, GRP_CLOCK});
        pads(6'h0, 6'h0, 6'h3f);
        // full table plus a command: entry three gives way
        wr(IDX_MAP, 32'h3625_1803);
        wr(IDX_COUNT, 32'h4);
        wr(IDX_CMD, {16'h0, 8'h15, GRP_CLOCK});
        pads(6'h27, {g[5], 2'h0, b1[5], 1'b0, b1[3]}, 6'h3d);
        $display("test command done");
    endtask : t_cmd

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // a run reaching 3000 cycles ends here; bus gives up on a hung handshake after 16
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            $display("mismatch run length expected 2999 seen %0d", cyc);
            tally_and_finish();
        end
    end

    initial begin
        rst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        flip = 1'b0;
        address = '0;
        writedata = '0;
        byteenable = '0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_table();
        t_analog();
        t_cmd();
        tally_and_finish();
    end
endmodule : tbr_router_tb
